// file: rtl/ast_top.v
// asynchronous serial transmitter with receiver, break and clock output
// Summary of operation
// - word length is 8 or 9 bits from word_length_select
// - in 9-bit mode without parity tx_ninth_bit is sent as the most significant bit
// - data bits leave serial_tx_out least significant bit first
// - start bit is low, stop bit is high
// - idle enabled line is high; disabled transmitter hands pin back to port
// - setting tx_enable sends one idle frame of ones before data
// - one logic-one bit follows the last break frame
// - tx_buffer_empty sets when buffer empties into shifter; gated interrupt request
// - write during transmission waits in holding buffer until frame ends
// - write while idle starts transmission and tx_buffer_empty sets at once
// - tx_complete sets after stop bit or break frame; gated interrupt request
// - clock pulses only on data bits; optional last pulse; phase, polarity set
// - enabled transmitter drives data and matching clock pulses
// - separate transmit and receive baud generators
// - conventional divider plus extended fine prescaler
// - parity generated on transmit and checked on receive
// - separate overrun, noise, framing and parity error flags
// - receive line is oversampled to reject noise
// - break frames repeat while send_break is set
// - lin mode with 8-bit words sends a 13-bit break
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "ast_consts.vh"

module ast_top (
    input  wire        i_clk_sys,
    input  wire        i_sys_rst,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    input  wire        i_serial_rx_in,
    input  wire        i_port_data,
    input  wire        i_cpu_irq_mask,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    output reg         o_serial_tx_out,
    output reg         o_tx_pin_owned,
    output reg         o_tx_clock_out,
    output reg         o_irq
);

localparam K_DATA  = 2'h0;
localparam K_IDLE  = 2'h1;
localparam K_BREAK = 2'h2;
localparam K_ONE   = 2'h3;

localparam RX_IDLE  = 2'h0;
localparam RX_START = 2'h1;
localparam RX_DATA  = 2'h2;
localparam RX_STOP  = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// registers and bus phase

reg  [7:0]  ctrl1_ff;
reg  [7:0]  ctrl2_ff;
reg  [7:0]  ctrl3_ff;
reg  [7:0]  baud_ff;
reg  [7:0]  rx_fine_ff;
reg  [7:0]  tx_fine_ff;
reg         wr_pend_ff;
reg         rd_pend_ff;
reg  [7:0]  addr_ff;
reg         armed_ff;
reg         tx_buffer_empty_ff;
reg         tc_ff;
reg         rx_full_ff;
reg         ovr_ff;
reg         nf_ff;
reg         fe_ff;
reg         pe_ff;
reg  [8:0]  rx_data_ff;
reg  [8:0]  hold_ff;
reg         hold_full_ff;
reg         idle_pend_ff;
reg         te_prev_ff;
reg         last_brk_ff;
reg         tx_busy_ff;
reg  [1:0]  kind_ff;
reg  [12:0] frame_ff;
reg  [3:0]  bits_left_ff;
reg  [3:0]  bit_pos_ff;
reg  [3:0]  tick_cnt_ff;
reg         rx_meta_ff;
reg         rx_sync_ff;
reg  [1:0]  rx_state_ff;
reg  [3:0]  rx_cnt_ff;
reg  [3:0]  rx_bits_ff;
reg  [1:0]  rx_votes_ff;
reg         rx_noisy_ff;
reg  [8:0]  rx_sr_ff;
reg  [31:0] rd_mux;

wire tx_tick;
wire rx_tick;
wire word9      = ctrl1_ff[`AST_C1_WORD_LEN];
wire par_en     = ctrl1_ff[`AST_C1_PARITY_EN];
wire par_odd    = ctrl1_ff[`AST_C1_PARITY_ODD];
wire tx_enable  = ctrl2_ff[`AST_C2_TX_EN];
wire rx_enable  = ctrl2_ff[`AST_C2_RX_EN];
wire send_break = ctrl2_ff[`AST_C2_SEND_BREAK];
wire lin_en     = ctrl3_ff[`AST_C3_LIN_EN];
wire [3:0] wlen = word9 ? 4'h9 : 4'h8;
wire [3:0] flen = wlen + 4'h2;

wire addr_ok  = i_hsel & i_htrans[1] & i_hready;
wire data_wr  = wr_pend_ff & (addr_ff == `AST_OFF_DATA);
wire stat_rd  = rd_pend_ff & (addr_ff == `AST_OFF_STATUS);
wire data_rd  = rd_pend_ff & (addr_ff == `AST_OFF_DATA);
wire tx_clear = data_wr & armed_ff;
wire rx_clear = data_rd & armed_ff;

wire [7:0] status_val = {tx_buffer_empty_ff, tc_ff, rx_full_ff, 1'b0, ovr_ff, nf_ff, fe_ff, pe_ff};

always @* begin
    rd_mux = 32'h00000000;
    if (addr_ff == `AST_OFF_STATUS) begin
        rd_mux = {24'h000000, status_val};
    end else if (addr_ff == `AST_OFF_DATA) begin
        rd_mux = {24'h000000, rx_data_ff[7:0]};
    end else if (addr_ff == `AST_OFF_BAUD) begin
        rd_mux = {24'h000000, baud_ff};
    end else if (addr_ff == `AST_OFF_CTRL1) begin
        rd_mux = {24'h000000, ctrl1_ff[7], rx_data_ff[8] & 1'b0 | ctrl1_ff[6], ctrl1_ff[5:0]};
    end else if (addr_ff == `AST_OFF_CTRL2) begin
        rd_mux = {24'h000000, ctrl2_ff};
    end else if (addr_ff == `AST_OFF_CTRL3) begin
        rd_mux = {24'h000000, ctrl3_ff};
    end else if (addr_ff == `AST_OFF_RX_FINE) begin
        rd_mux = {24'h000000, rx_fine_ff};
    end else if (addr_ff == `AST_OFF_TX_FINE) begin
        rd_mux = {24'h000000, tx_fine_ff};
    end
end

// writes take effect at the end of a zero-wait data phase; reads add one wait state
always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        wr_pend_ff  <= 1'b0;
        rd_pend_ff  <= 1'b0;
        addr_ff     <= 8'h00;
        o_hreadyout <= 1'b1;
        o_hresp     <= 1'b0;
        o_hrdata    <= 32'h00000000;
        ctrl1_ff    <= 8'h00;
        ctrl2_ff    <= 8'h00;
        ctrl3_ff    <= 8'h00;
        baud_ff     <= 8'h00;
        rx_fine_ff  <= 8'h00;
        tx_fine_ff  <= 8'h00;
        armed_ff    <= 1'b0;
    end else begin
        wr_pend_ff  <= addr_ok & i_hwrite;
        rd_pend_ff  <= addr_ok & ~i_hwrite;
        o_hreadyout <= ~(addr_ok & ~i_hwrite);
        if (addr_ok) begin
            addr_ff <= (i_haddr[31:8] == 24'h000000) ? i_haddr[7:0] : 8'hff;
        end
        if (rd_pend_ff) begin
            o_hrdata <= rd_mux;
        end
        if (wr_pend_ff) begin
            if (addr_ff == `AST_OFF_BAUD) begin
                baud_ff <= i_hwdata[7:0];
            end else if (addr_ff == `AST_OFF_CTRL1) begin
                ctrl1_ff <= {1'b0, i_hwdata[6:0]};
            end else if (addr_ff == `AST_OFF_CTRL2) begin
                ctrl2_ff <= i_hwdata[7:0];
            end else if (addr_ff == `AST_OFF_CTRL3) begin
                ctrl3_ff <= i_hwdata[7:0];
            end else if (addr_ff == `AST_OFF_RX_FINE) begin
                rx_fine_ff <= i_hwdata[7:0];
            end else if (addr_ff == `AST_OFF_TX_FINE) begin
                tx_fine_ff <= i_hwdata[7:0];
            end
        end
        if (stat_rd) begin
            armed_ff <= 1'b1;
        end else if (data_wr | data_rd) begin
            armed_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// baud generators

ast_baud_gen u_tx_baud (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_enable  (tx_enable),
    .i_pr_sel  (baud_ff[`AST_BD_PR_HI:`AST_BD_PR_LO]),
    .i_div_sel (baud_ff[`AST_BD_TX_HI:`AST_BD_TX_LO]),
    .i_fine    (tx_fine_ff),
    .o_tick    (tx_tick)
);

ast_baud_gen u_rx_baud (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_enable  (rx_enable),
    .i_pr_sel  (baud_ff[`AST_BD_PR_HI:`AST_BD_PR_LO]),
    .i_div_sel (baud_ff[`AST_BD_RX_HI:`AST_BD_RX_LO]),
    .i_fine    (rx_fine_ff),
    .o_tick    (rx_tick)
);

////////////////////////////////////////////////////////////////////////////////
// transmitter

wire bit_end   = tx_busy_ff & tx_tick & (tick_cnt_ff == `AST_TICK_LAST);
wire frame_end = bit_end & (bits_left_ff == 4'h1);
wire can_start = tx_enable & (~tx_busy_ff | frame_end);
wire te_rise   = tx_enable & ~te_prev_ff;

// parity replaces the most significant bit of the word
wire [8:0] word_raw = word9 ? hold_ff : {1'b0, hold_ff[7:0]};
wire       par_bit  = (word9 ? ^hold_ff[7:0] : ^hold_ff[6:0]) ^ par_odd;
reg  [8:0] word_tx;

always @* begin
    word_tx = word_raw;
    if (par_en & word9) begin
        word_tx[8] = par_bit;
    end else if (par_en) begin
        word_tx[7] = par_bit;
    end
end

// next frame priority: break, closing one bit, idle frame, data
wire start_brk  = can_start & send_break;
wire start_one  = can_start & ~send_break & last_brk_ff;
wire start_idle = can_start & ~send_break & ~last_brk_ff & idle_pend_ff;
wire start_data = can_start & ~send_break & ~last_brk_ff & ~idle_pend_ff
                  & hold_full_ff;
wire any_start  = start_brk | start_one | start_idle | start_data;

always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        tx_busy_ff   <= 1'b0;
        kind_ff      <= K_IDLE;
        frame_ff     <= 13'h1fff;
        bits_left_ff <= 4'h0;
        bit_pos_ff   <= 4'h0;
        tick_cnt_ff  <= 4'h0;
        hold_ff      <= 9'h000;
        hold_full_ff <= 1'b0;
        idle_pend_ff <= 1'b0;
        te_prev_ff   <= 1'b0;
        last_brk_ff  <= 1'b0;
        tx_buffer_empty_ff      <= 1'b1;
        tc_ff        <= 1'b1;
    end else begin
        te_prev_ff <= tx_enable;
        if (te_rise) begin
            idle_pend_ff <= 1'b1;
        end else if (start_idle) begin
            idle_pend_ff <= 1'b0;
        end
        // a write always lands in the holding buffer; disabling loses it
        if (data_wr) begin
            hold_ff      <= {ctrl1_ff[`AST_C1_TX_NINTH], i_hwdata[7:0]};
            hold_full_ff <= 1'b1;
        end else if (start_data | ~tx_enable) begin
            hold_full_ff <= 1'b0;
        end
        if (start_data) begin
            tx_buffer_empty_ff <= 1'b1;
        end else if (tx_clear) begin
            tx_buffer_empty_ff <= 1'b0;
        end
        if (frame_end & ((kind_ff == K_DATA) | (kind_ff == K_BREAK))) begin
            tc_ff <= 1'b1;
        end else if (tx_clear) begin
            tc_ff <= 1'b0;
        end
        if (start_brk) begin
            last_brk_ff <= 1'b1;
        end else if (start_one) begin
            last_brk_ff <= 1'b0;
        end
        if (any_start) begin
            tx_busy_ff  <= 1'b1;
            tick_cnt_ff <= 4'h0;
            bit_pos_ff  <= 4'h0;
            if (start_brk) begin
                kind_ff      <= K_BREAK;
                frame_ff     <= 13'h0000;
                bits_left_ff <= (lin_en & ~word9) ? `AST_LIN_BREAK_BITS : flen;
            end else if (start_one) begin
                kind_ff      <= K_ONE;
                frame_ff     <= 13'h1fff;
                bits_left_ff <= 4'h1;
            end else if (start_idle) begin
                kind_ff      <= K_IDLE;
                frame_ff     <= 13'h1fff;
                bits_left_ff <= flen;
            end else if (word9) begin
                kind_ff      <= K_DATA;
                frame_ff     <= {2'h3, word_tx, 1'b0, 1'b0} >> 1;
                bits_left_ff <= flen;
            end else begin
                kind_ff      <= K_DATA;
                frame_ff     <= {4'hf, word_tx[7:0], 1'b0};
                bits_left_ff <= flen;
            end
        end else if (frame_end) begin
            tx_busy_ff <= 1'b0;
        end else if (tx_busy_ff & tx_tick) begin
            tick_cnt_ff <= tick_cnt_ff + 4'h1;
            if (bit_end) begin
                frame_ff     <= {1'b1, frame_ff[12:1]};
                bits_left_ff <= bits_left_ff - 4'h1;
                bit_pos_ff   <= bit_pos_ff + 4'h1;
            end
        end
    end
end

// clock pulses only inside data bits, optionally not on the last one
wire data_bit  = tx_busy_ff & (kind_ff == K_DATA) & (bit_pos_ff != 4'h0)
                 & (bit_pos_ff <= wlen)
                 & ((bit_pos_ff != wlen) | ctrl3_ff[`AST_C3_LAST_PULSE]);
wire clk_phase = ctrl3_ff[`AST_C3_CLK_PHA] ? (tick_cnt_ff < `AST_TICK_HALF)
                                           : (tick_cnt_ff >= `AST_TICK_HALF);
wire line_lvl  = tx_busy_ff ? frame_ff[0] : 1'b1;

always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        o_serial_tx_out <= 1'b1;
        o_tx_pin_owned  <= 1'b0;
        o_tx_clock_out  <= 1'b0;
        o_irq           <= 1'b0;
    end else begin
        o_serial_tx_out <= tx_enable ? line_lvl : i_port_data;
        o_tx_pin_owned  <= tx_enable;
        o_tx_clock_out  <= ctrl3_ff[`AST_C3_CLK_POL]
                           ^ (tx_enable & ctrl3_ff[`AST_C3_CLK_EN] & data_bit & clk_phase);
        o_irq <= ~i_cpu_irq_mask
                 & ((tx_buffer_empty_ff & ctrl2_ff[`AST_C2_TX_EMPTY_IE])
                    | (tc_ff & ctrl2_ff[`AST_C2_TX_DONE_IE])
                    | ((rx_full_ff | ovr_ff) & ctrl2_ff[`AST_C2_RX_IE]));
    end
end

////////////////////////////////////////////////////////////////////////////////
// receiver

wire rx_mid  = rx_tick & (rx_cnt_ff == `AST_SAMPLE_C);
wire rx_maj  = (rx_votes_ff[0] & rx_votes_ff[1]) | (rx_votes_ff[0] & rx_sync_ff)
               | (rx_votes_ff[1] & rx_sync_ff);
wire rx_dis  = (rx_votes_ff[0] != rx_votes_ff[1]) | (rx_votes_ff[1] != rx_sync_ff);
wire [8:0] rx_word = word9 ? rx_sr_ff : {1'b0, rx_sr_ff[8:1]};
wire rx_par_bad    = par_en & ((^rx_word) != par_odd);
wire rx_done       = (rx_state_ff == RX_STOP) & rx_mid;

always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        rx_meta_ff  <= 1'b1;
        rx_sync_ff  <= 1'b1;
        rx_state_ff <= RX_IDLE;
        rx_cnt_ff   <= 4'h0;
        rx_bits_ff  <= 4'h0;
        rx_votes_ff <= 2'h3;
        rx_noisy_ff <= 1'b0;
        rx_sr_ff    <= 9'h000;
        rx_data_ff  <= 9'h000;
        rx_full_ff  <= 1'b0;
        ovr_ff      <= 1'b0;
        nf_ff       <= 1'b0;
        fe_ff       <= 1'b0;
        pe_ff       <= 1'b0;
    end else begin
        rx_meta_ff <= i_serial_rx_in;
        rx_sync_ff <= rx_meta_ff;
        if (rx_tick) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == `AST_SAMPLE_A) begin
                rx_votes_ff[0] <= rx_sync_ff;
            end
            if (rx_cnt_ff == `AST_SAMPLE_B) begin
                rx_votes_ff[1] <= rx_sync_ff;
            end
        end
        case (rx_state_ff)
            RX_IDLE: begin
                rx_noisy_ff <= 1'b0;
                if (rx_enable & rx_tick & ~rx_sync_ff) begin
                    rx_state_ff <= RX_START;
                    rx_cnt_ff   <= 4'h1;
                end
            end
            RX_START: begin
                if (rx_mid) begin
                    rx_noisy_ff <= rx_dis;
                    rx_bits_ff  <= 4'h0;
                    rx_state_ff <= rx_maj ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_mid) begin
                    rx_sr_ff    <= {rx_maj, rx_sr_ff[8:1]};
                    rx_noisy_ff <= rx_noisy_ff | rx_dis;
                    rx_bits_ff  <= rx_bits_ff + 4'h1;
                    if (rx_bits_ff == wlen - 4'h1) begin
                        rx_state_ff <= RX_STOP;
                    end
                end
            end
            default: begin
                if (rx_mid) begin
                    rx_state_ff <= RX_IDLE;
                end
            end
        endcase
        // on overrun the held word is kept and the new one dropped
        if (rx_done & rx_full_ff) begin
            ovr_ff <= 1'b1;
        end else if (rx_clear) begin
            ovr_ff <= 1'b0;
        end
        if (rx_done & ~rx_full_ff) begin
            rx_full_ff <= 1'b1;
            rx_data_ff <= rx_word;
            nf_ff      <= rx_noisy_ff | rx_dis;
            fe_ff      <= ~rx_maj;
            pe_ff      <= rx_par_bad;
        end else if (rx_clear) begin
            rx_full_ff <= 1'b0;
            nf_ff      <= 1'b0;
            fe_ff      <= 1'b0;
            pe_ff      <= 1'b0;
        end
    end
end

endmodule // ast_top

// file: rtl/ast_consts.vh
// constants for the asynchronous serial transmitter block
`ifndef AST_CONSTS_VH
`define AST_CONSTS_VH

// register byte offsets
`define AST_OFF_STATUS      8'h00
`define AST_OFF_DATA        8'h04
`define AST_OFF_BAUD        8'h08
`define AST_OFF_CTRL1       8'h0c
`define AST_OFF_CTRL2       8'h10
`define AST_OFF_CTRL3       8'h14
`define AST_OFF_RX_FINE     8'h18
`define AST_OFF_TX_FINE     8'h1c

// status bits
`define AST_ST_TX_EMPTY     7
`define AST_ST_TX_DONE      6
`define AST_ST_RX_FULL      5
`define AST_ST_OVERRUN      3
`define AST_ST_NOISE        2
`define AST_ST_FRAMING      1
`define AST_ST_PARITY       0
`define AST_STATUS_RST      8'hc0

// control one bits
`define AST_C1_RX_NINTH     7
`define AST_C1_TX_NINTH     6
`define AST_C1_WORD_LEN     4
`define AST_C1_PARITY_EN    2
`define AST_C1_PARITY_ODD   1

// control two bits
`define AST_C2_TX_EMPTY_IE  7
`define AST_C2_TX_DONE_IE   6
`define AST_C2_RX_IE        5
`define AST_C2_TX_EN        3
`define AST_C2_RX_EN        2
`define AST_C2_SEND_BREAK   0

// control three bits
`define AST_C3_LIN_EN       6
`define AST_C3_CLK_EN       3
`define AST_C3_CLK_POL      2
`define AST_C3_CLK_PHA      1
`define AST_C3_LAST_PULSE   0

// baud select fields
`define AST_BD_PR_HI        7
`define AST_BD_PR_LO        6
`define AST_BD_TX_HI        5
`define AST_BD_TX_LO        3
`define AST_BD_RX_HI        2
`define AST_BD_RX_LO        0

// coarse prescaler values
`define AST_PR_VAL0         5'h01
`define AST_PR_VAL1         5'h03
`define AST_PR_VAL2         5'h04
`define AST_PR_VAL3         5'h0d

// frame timing
`define AST_TICK_LAST       4'hf
`define AST_SAMPLE_A        4'h7
`define AST_SAMPLE_B        4'h8
`define AST_SAMPLE_C        4'h9
`define AST_TICK_HALF       4'h8
`define AST_LIN_BREAK_BITS  4'hd

`endif

// file: rtl/ast_baud_gen.v
// baud generator producing one tick per sixteenth of a bit
`timescale 1ns/10ps
`include "ast_consts.vh"

module ast_baud_gen (
    input  wire       i_clk_sys,
    input  wire       i_sys_rst,
    input  wire       i_enable,
    input  wire [1:0] i_pr_sel,
    input  wire [2:0] i_div_sel,
    input  wire [7:0] i_fine,
    output reg        o_tick
);

reg  [4:0]  pr_val;
reg  [19:0] cnt_ff;
wire [11:0] pr_tr    = {7'h00, pr_val} << i_div_sel;
// a fine prescaler of zero leaves only the conventional divider active
wire [7:0]  fine_val = (i_fine == 8'h00) ? 8'h01 : i_fine;
wire [19:0] divisor  = {8'h00, pr_tr} * {12'h000, fine_val};

always @* begin
    case (i_pr_sel)
        2'h0:    pr_val = `AST_PR_VAL0;
        2'h1:    pr_val = `AST_PR_VAL1;
        2'h2:    pr_val = `AST_PR_VAL2;
        default: pr_val = `AST_PR_VAL3;
    endcase
end

always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        cnt_ff <= 20'h00000;
        o_tick <= 1'b0;
    end else if (!i_enable) begin
        cnt_ff <= 20'h00000;
        o_tick <= 1'b0;
    end else if (cnt_ff == 20'h00000) begin
        cnt_ff <= divisor - 20'h00001;
        o_tick <= 1'b1;
    end else begin
        cnt_ff <= cnt_ff - 20'h00001;
        o_tick <= 1'b0;
    end
end

endmodule // ast_baud_gen

// file: dv/ast_top_checker.sv
// port-level assertions for the serial transmitter
`timescale 1ns/10ps
module ast_top_checker (
    input logic        i_clk_sys,
    input logic        i_sys_rst,
    input logic        i_hsel,
    input logic [1:0]  i_htrans,
    input logic        i_hwrite,
    input logic        i_hready,
    input logic        i_port_data,
    input logic        i_cpu_irq_mask,
    input logic [31:0] o_hrdata,
    input logic        o_hreadyout,
    input logic        o_hresp,
    input logic        o_serial_tx_out,
    input logic        o_tx_pin_owned,
    input logic        o_irq
);
////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    wire acc = i_hsel && i_htrans[1] && i_hready;
    wire own = o_tx_pin_owned;
    wire tx = o_serial_tx_out;
    property p_port; !own && !$past(own) |-> tx == $past(i_port_data); endproperty
    a_port: assert property (p_port) else $error("pin not following port");
    property p_hold; $changed(tx) && own && $past(own) |=> $stable(tx)[*8]; endproperty
    a_hold: assert property (p_hold) else $error("bit too short");
    property p_idle; $rose(own) |=> tx[*8]; endproperty
    a_idle: assert property (p_idle) else $error("no idle frame");
    property p_mask; i_cpu_irq_mask |=> !o_irq; endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_rdw; acc && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout; endproperty
    a_rdw: assert property (p_rdw) else $error("read wait state wrong");
    property p_wrz; acc && i_hwrite |=> o_hreadyout; endproperty
    a_wrz: assert property (p_wrz) else $error("write stalled");
    property p_okay; o_hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_upper; $rose(o_hreadyout) |-> o_hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read upper bits set");
    c_rd: cover property (acc && !i_hwrite);
    c_wr: cover property (acc && i_hwrite);
    c_start: cover property ($fell(tx) && own);
endmodule // ast_top_checker

bind ast_top ast_top_checker ast_top_checker_i (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .i_port_data(i_port_data), .i_cpu_irq_mask(i_cpu_irq_mask),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_serial_tx_out(o_serial_tx_out), .o_tx_pin_owned(o_tx_pin_owned), .o_irq(o_irq));

// file: dv/ast_line_model.sv
// far-end equipment that samples every frame with a start bit on the line and echoes it back
`timescale 1ns/10ps
module ast_line_model #(
    parameter int BIT_CYC = 16
) (
    input  logic i_clk_sys,
    input  logic i_line,
    input  logic i_nine,
    output logic o_rx_line
);
    logic [9:0] got_q[$];
    logic [9:0] w;
    int         nb;
    assign o_rx_line = i_line;
    initial begin
        forever begin
            @(negedge i_line);
            w = 10'h0;
            nb = i_nine ? 10 : 9;
            repeat (BIT_CYC / 2) @(posedge i_clk_sys);
            for (int k = 0; k < nb; k++) begin // lsb first, stop last
                repeat (BIT_CYC) @(posedge i_clk_sys);
                w[k] = i_line;
            end
            got_q.push_back(w);
        end
    end
endmodule // ast_line_model

// file: dv/tb_async_serial_transmitter.sv
// self-checking bench for the serial transmitter
`timescale 1ns/10ps
`include "ast_consts.vh"
module tb_async_serial_transmitter;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwr = 1'b0;
    logic        port = 1'b1, mask = 1'b0, nine = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hready, hresp, tx, own, sclk, irq, rxl;
    int          error_cnt = 0, total_checks = 0, n, sck_n = 0;
    time         t0;
    ast_top ast_top_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .i_serial_rx_in(rxl), .i_port_data(port), .i_cpu_irq_mask(mask),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_serial_tx_out(tx),
        .o_tx_pin_owned(own), .o_tx_clock_out(sclk), .o_irq(irq));
    ast_line_model ast_line_model_i (.i_clk_sys(clk), .i_line(tx), .i_nine(nine),
        .o_rx_line(rxl));
    initial forever #20 clk = ~clk;
    always @(posedge sclk) sck_n++;
////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic aph(input logic [7:0] a, input logic w);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwr <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
    endtask
    task automatic dph;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        dph;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        aph(a, 1'b0);
        dph;
        chk(hrdata & m, e);
    endtask
    task automatic wait_tx(input logic v);
        n = 0;
        while (tx !== v && n < 999) begin
            @(posedge clk);
            n++;
        end
        if (tx !== v) error_cnt++;
    endtask
    task automatic wait_q(input int k);
        for (int i = 0; i < 999 && ast_line_model_i.got_q.size() < k; i++) @(posedge clk);
        if (ast_line_model_i.got_q.size() < k) error_cnt++;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
////////////////////////////////////////
    task automatic t_frames;
        rdc(`AST_OFF_STATUS, 32'hff, 32'hc0);
        rdc(8'h20, 32'hffffffff, 32'h0);
        wr(`AST_OFF_CTRL2, 32'h0c);
        rdc(`AST_OFF_STATUS, 32'hffffff00, 32'h0);
        wr(`AST_OFF_DATA, 32'h35);
        wait_tx(1'b0);
        chk(n > 140 && n < 170, 1'b1);
        rdc(`AST_OFF_STATUS, 32'h80, 32'h80);
        wr(`AST_OFF_DATA, 32'hca);
        rdc(`AST_OFF_STATUS, 32'h80, 32'h00);
        wait_q(2);
        chk(ast_line_model_i.got_q[0], 32'h135);
        chk(ast_line_model_i.got_q[1], 32'h1ca);
        repeat (12) @(posedge clk);
        rdc(`AST_OFF_STATUS, 32'hef, 32'he8);
        rdc(`AST_OFF_DATA, 32'hff, 32'h35);
        $display("frame test done");
    endtask
    task automatic t_nine;
        ast_line_model_i.got_q.delete();
        nine <= 1'b1;
        wr(`AST_OFF_CTRL1, 32'h50);
        wr(`AST_OFF_CTRL3, 32'h09);
        sck_n = 0;
        rdc(`AST_OFF_STATUS, 32'hffffff00, 32'h0);
        wr(`AST_OFF_DATA, 32'h0f);
        rdc(`AST_OFF_STATUS, 32'h40, 32'h0);
        wait_q(1);
        chk(ast_line_model_i.got_q[0], 32'h30f);
        chk(sck_n, 9);
        repeat (24) @(posedge clk);
        wr(`AST_OFF_CTRL1, 32'h0);
        nine <= 1'b0;
        $display("nine bit test done");
    endtask
    task automatic t_break;
        ast_line_model_i.got_q.delete();
        wr(`AST_OFF_CTRL3, 32'h48);
        sck_n = 0;
        wr(`AST_OFF_CTRL2, 32'h09);
        wait_tx(1'b0);
        t0 = $time;
        wr(`AST_OFF_CTRL2, 32'h08);
        rdc(`AST_OFF_STATUS, 32'hffffff00, 32'h0);
        wr(`AST_OFF_DATA, 32'ha5);
        wait_tx(1'b1);
        chk(32'(($time - t0) / 40), 32'd208);
        t0 = $time;
        wait_tx(1'b0);
        chk(32'(($time - t0) / 40), 32'd16);
        wait_q(2);
        chk(ast_line_model_i.got_q[1], 32'h1a5);
        chk(ast_line_model_i.got_q[0], 32'h0);
        chk(sck_n, 7);
        wr(`AST_OFF_CTRL3, 32'h0);
        $display("break test done");
    endtask
    task automatic t_irq_port;
        mask <= 1'b1;
        wr(`AST_OFF_CTRL2, 32'h88);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        mask <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        wr(`AST_OFF_CTRL2, 32'h48);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        wr(`AST_OFF_CTRL2, 32'h0);
        port <= 1'b0;
        repeat (3) @(posedge clk);
        chk({own, tx}, 32'h0);
        $display("irq and port test done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_frames;
        t_nine;
        t_break;
        t_irq_port;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict;
    end
endmodule // tb_async_serial_transmitter
